// >>> lpw_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef LPW_REGS_SVH
`define LPW_REGS_SVH
`define LPW_WAKEUP_CONTROL_OFS   12'h0f7
`define LPW_POWER_DOWN_OFS       12'h0fb
`define LPW_BUS_PARK_OFS         12'h82a
`define LPW_OP_MODE_OFS          12'h0fa
`define LPW_WAKEUP_RESET         8'h00
`define LPW_BUS_PARK_RESET       8'h00
`define LPW_OP_MODE_RESET        8'h00
`define LPW_WUC_MASK             8'h77
`define LPW_EV_POS               4
`define LPW_EN_POS               0
`define LPW_PARK_EN_BIT          0
`define LPW_PARK_DATA_BIT        1
`define LPW_PARK_ADDR_BIT        2
`define LPW_SUPER_BIT            5
`define LPW_WP_BIT               7
`define LPW_WAKE_IRQ_LEVEL       3'h4
`define LPW_WAIT_CLOCKS          5'h10
`endif

// >>> lpw_pkg.sv
// types for the low-power entry and wake-up controller
package lpw_pkg;
    typedef enum logic [2:0] {
        LPW_RUN     = 3'h0,
        LPW_WAIT    = 3'h1,
        LPW_REQUEST = 3'h3,
        LPW_LOW     = 3'h2
    } lpw_state_type;

    typedef struct packed {
        lpw_state_type state;
        logic [4:0]    wait_cnt;
        logic [2:0]    mask;
        logic [1:0]    mode;
        logic [2:0]    ev;
        logic [2:0]    en;
        logic [2:0]    park;
        logic [7:0]    opmode;
        logic [7:0]    pwrd;
        logic [1:0]    pin_prev;
        logic [7:0]    rdata;
        logic          br;
    } lpw_regs_type;
endpackage : lpw_pkg

// >>> lpw_ctrl.sv
// low-power entry, bus parking and wake-up control for the peripheral section
`timescale 1ns/100ps
`include "lpw_regs.svh"

module lpw_ctrl (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // register access from the core
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // core bus arbitration and interrupt state
    input  wire logic        bus_grant,
    input  wire logic        bus_grant_acknowledge,
    input  wire logic [2:0]  core_irq_level,
    output logic             bus_request,
    // wake sources
    input  wire logic        hard_reset_n,
    input  wire logic        wake_pin_a,
    input  wire logic        wake_pin_b,
    input  wire logic        periodic_interrupt_timer,
    // wake interrupt to the core
    output logic             wake_irq,
    output logic      [2:0]  wake_irq_level,
    // power state and clock divide
    output logic      [1:0]  low_power_state,
    output logic             clocks_stopped,
    output logic      [3:0]  clock_divide_field,
    // external bus pins during low power
    output logic             data_bus_out,
    output logic             data_bus_oe,
    output logic             addr_bus_out,
    output logic             addr_bus_oe
);

    lpw_pkg::lpw_regs_type r_q;
    lpw_pkg::lpw_regs_type r_d;

    logic       pending;
    logic [1:0] pin_fall;
    logic       wake;
    logic       in_low;

    ////////////////////////////////////////////////////////////////////////
    // wake qualification
    assign pin_fall = r_q.pin_prev & ~{wake_pin_b, wake_pin_a};
    assign pending  = |(r_q.ev & r_q.en);
    assign wake     = pending | ~hard_reset_n;
    assign in_low   = (r_q.state == lpw_pkg::LPW_LOW);

    ////////////////////////////////////////////////////////////////////////
    // next state: registers, event flags and the entry sequence
    always_comb
    begin
        r_d = r_q;
        r_d.pin_prev = {wake_pin_b, wake_pin_a};
        r_d.rdata = 8'h00;
        if (reg_wr && reg_addr == `LPW_WAKEUP_CONTROL_OFS)
        begin
            // event bits write-one-to-clear, enable bits written directly; bits 7 and 3 are not stored
            r_d.ev = r_q.ev & ~reg_wdata[6:4];
            r_d.en = reg_wdata[2:0];
        end
        if (reg_wr && reg_addr == `LPW_BUS_PARK_OFS)
            r_d.park = reg_wdata[2:0];
        // write protect bit locks the mode register once set
        if (reg_wr && reg_addr == `LPW_OP_MODE_OFS && !r_q.opmode[`LPW_WP_BIT])
            r_d.opmode = reg_wdata;
        if (reg_wr && reg_addr == `LPW_POWER_DOWN_OFS)
            r_d.pwrd = reg_wdata;
        // a set in the same cycle as a clear wins
        r_d.ev = r_d.ev | {periodic_interrupt_timer, pin_fall};
        if (reg_rd)
        begin
            case (reg_addr)
                `LPW_WAKEUP_CONTROL_OFS:
                    r_d.rdata = {1'b0, r_q.ev, 1'b0, r_q.en};
                `LPW_BUS_PARK_OFS:  r_d.rdata = {5'h00, r_q.park};
                `LPW_OP_MODE_OFS:   r_d.rdata = r_q.opmode;
                `LPW_POWER_DOWN_OFS: r_d.rdata = r_q.pwrd;
                default:            r_d.rdata = 8'h00;
            endcase
        end
        case (r_q.state)
            lpw_pkg::LPW_RUN:
            begin
                r_d.br = 1'b0;
                // supervisor bit must be set, mode non-normal
                if (reg_wr && reg_addr == `LPW_POWER_DOWN_OFS
                    && reg_wdata[`LPW_SUPER_BIT]
                    && r_q.opmode[1:0] != 2'h0 && !wake)
                begin
                    r_d.state    = lpw_pkg::LPW_WAIT;
                    r_d.mask     = reg_wdata[2:0];
                    r_d.mode     = r_q.opmode[1:0];
                    r_d.wait_cnt = 5'h00;
                end
            end
            lpw_pkg::LPW_WAIT:
            begin
                if (wake || core_irq_level > r_q.mask)
                    r_d.state = lpw_pkg::LPW_RUN;
                else if (bus_grant || bus_grant_acknowledge)
                    r_d.wait_cnt = 5'h00;
                else if (r_q.wait_cnt == `LPW_WAIT_CLOCKS - 5'h01)
                begin
                    r_d.state = lpw_pkg::LPW_REQUEST;
                    r_d.br    = 1'b1;
                end
                else
                    r_d.wait_cnt = r_q.wait_cnt + 5'h01;
            end
            lpw_pkg::LPW_REQUEST:
            begin
                if (wake || core_irq_level > r_q.mask)
                begin
                    r_d.state = lpw_pkg::LPW_RUN;
                    r_d.br    = 1'b0;
                end
                else if (bus_grant)
                    r_d.state = lpw_pkg::LPW_LOW;
            end
            lpw_pkg::LPW_LOW:
            begin
                // wake restarts clocks and hands the bus back
                if (wake)
                begin
                    r_d.state = lpw_pkg::LPW_RUN;
                    r_d.br    = 1'b0;
                end
            end
            default:
            begin
                r_d.state = lpw_pkg::LPW_RUN;
                r_d.br    = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            r_q          <= '0;
            r_q.state    <= lpw_pkg::LPW_RUN;
            r_q.ev       <= 3'h0;
            r_q.en       <= 3'h0;
            r_q.park     <= 3'(`LPW_BUS_PARK_RESET);
            r_q.opmode   <= `LPW_OP_MODE_RESET;
            r_q.pin_prev <= 2'h3;
        end
        else
            r_q <= r_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; the clock stop is released combinationally by wake so the
    // clocks restart without waiting on a stopped clock edge
    assign reg_rdata          = r_q.rdata;
    assign bus_request        = r_q.br;
    assign clocks_stopped     = in_low & ~wake;
    assign low_power_state    = in_low ? r_q.mode : 2'h0;
    assign clock_divide_field = r_q.opmode[6:3];
    assign wake_irq           = pending;
    assign wake_irq_level     = `LPW_WAKE_IRQ_LEVEL;
    // park: 0 on level bit drives high, 1 drives low
    assign data_bus_oe  = in_low & r_q.park[`LPW_PARK_EN_BIT];
    assign addr_bus_oe  = in_low & r_q.park[`LPW_PARK_EN_BIT];
    assign data_bus_out = ~r_q.park[`LPW_PARK_DATA_BIT];
    assign addr_bus_out = ~r_q.park[`LPW_PARK_ADDR_BIT];

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_entry;
        r_q.state == lpw_pkg::LPW_REQUEST ##1 bus_grant;
    endsequence

    a_super_bit_gate: assert property (@(posedge sys_clk) disable iff (rst)
        (r_q.state == lpw_pkg::LPW_RUN && reg_wr
         && reg_addr == `LPW_POWER_DOWN_OFS && !reg_wdata[5])
        |=> r_q.state == lpw_pkg::LPW_RUN)
        else $error("power-down started without supervisor bit");
    a_wait_count: assert property (@(posedge sys_clk) disable iff (rst)
        ($rose(r_q.state == lpw_pkg::LPW_WAIT))
        |-> !bus_request [*8])
        else $error("bus request before wait completed");
    a_request_held: assert property (@(posedge sys_clk) disable iff (rst)
        (r_q.state == lpw_pkg::LPW_REQUEST) |-> bus_request)
        else $error("bus request missing while waiting for grant");
    a_low_needs_grant: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(in_low) |-> $past(bus_grant))
        else $error("low power entered without grant");
    a_no_entry_pend: assert property (@(posedge sys_clk) disable iff (rst)
        (r_q.state == lpw_pkg::LPW_RUN && pending && reg_wr
         && reg_addr == `LPW_POWER_DOWN_OFS)
        |=> r_q.state == lpw_pkg::LPW_RUN)
        else $error("power-down entered with pending event");
    a_pin_a_flag: assert property (@(posedge sys_clk) disable iff (rst)
        ($fell(wake_pin_a)) |=> r_q.ev[0])
        else $error("pin a edge did not set flag");
    a_pin_b_flag: assert property (@(posedge sys_clk) disable iff (rst)
        ($fell(wake_pin_b)) |=> r_q.ev[1])
        else $error("pin b edge did not set flag");
    a_timer_flag: assert property (@(posedge sys_clk) disable iff (rst)
        periodic_interrupt_timer |=> r_q.ev[2])
        else $error("timer timeout did not set flag");
    a_wake_exit: assert property (@(posedge sys_clk) disable iff (rst)
        (in_low && wake) |=> r_q.state == lpw_pkg::LPW_RUN && !bus_request)
        else $error("wake did not return to run");
    a_park_float: assert property (@(posedge sys_clk) disable iff (rst)
        (in_low && !r_q.park[0]) |-> !data_bus_oe && !addr_bus_oe)
        else $error("bus driven while parking disabled");
    a_entry_seq: assert property (@(posedge sys_clk) disable iff (rst)
        s_entry |-> ##1 (in_low || r_q.state == lpw_pkg::LPW_RUN))
        else $error("grant did not complete entry");
endmodule : lpw_ctrl

// >>> lpw_core_model.sv
// core arbitration stand-in: grants the bus a set time after a request
`timescale 1ns/100ps
module lpw_core_model (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // arbitration
    input  wire logic       bus_request,
    input  wire logic [3:0] grant_delay,
    output logic            bus_grant
);
    logic [3:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////
    // grant once the request has stood grant_delay + 1 clocks; a slow core
    // is modelled by a large delay, and grant drops on the first clock edge that sees the request low
    always_ff @(posedge sys_clk)
    begin
        if (rst || !bus_request)
        begin
            cnt_q     <= 4'h0;
            bus_grant <= 1'b0;
        end
        else if (cnt_q == grant_delay)
            bus_grant <= 1'b1;
        else
            cnt_q <= cnt_q + 4'h1;
    end
endmodule : lpw_core_model

// >>> lpw_ctrl_test.sv
// randomised self-checking bench for the low-power entry and wake control
`timescale 1ns/100ps
module lpw_ctrl_test;
    logic        sys_clk, rst, reg_wr, reg_rd, bus_grant, wake_irq;
    logic        hard_reset_n, wake_pin_a, wake_pin_b, bus_request;
    logic        periodic_interrupt_timer, bus_grant_acknowledge;
    logic        clocks_stopped, data_bus_out, data_bus_oe;
    logic        addr_bus_out, addr_bus_oe;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, p, e;
    logic [3:0]  clock_divide_field, grant_delay, dv;
    logic [2:0]  core_irq_level, wake_irq_level;
    logic [1:0]  low_power_state;
    int          fails, check_count, n, m, r;
    int          cyc = 0;

    lpw_ctrl u_dut (
        .sys_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .bus_grant, .bus_grant_acknowledge, .core_irq_level, .bus_request,
        .hard_reset_n, .wake_pin_a, .wake_pin_b, .periodic_interrupt_timer,
        .wake_irq, .wake_irq_level, .low_power_state, .clocks_stopped,
        .clock_divide_field, .data_bus_out, .data_bus_oe, .addr_bus_out,
        .addr_bus_oe
    );
    lpw_core_model u_core (.sys_clk, .rst, .bus_request, .grant_delay,
        .bus_grant);

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard; whole run needs well under a thousand cycles
    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared tasks; every drive lands 1 ns after the rising edge
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge sys_clk);
        #1;
        reg_rd = 1'b0;
        chk(reg_rdata, exp);
    endtask : rd
    // edges from the last taken edge until bus request shows, at most 40
    task automatic cnt();
        for (n = 0; n < 40 && bus_request !== 1'b1; n++)
        begin
            @(posedge sys_clk);
            #1;
        end
    endtask : cnt
    // bounded wait: 0 clocks stopped, 1 wake interrupt, 2 request gone
    task automatic wt(input int k);
        int i;
        for (i = 0; i < 60; i++)
        begin
            if (k == 0 ? clocks_stopped === 1'b1 : k == 1 ?
                wake_irq === 1'b1 : bus_request === 1'b0)
                break;
            @(posedge sys_clk);
            #1;
        end
        chk(i < 60, 1'b1);
    endtask : wt
    // power-down write that must not start a request
    task automatic none(input logic [7:0] op);
        wr(12'h0fb, op);
        cnt();
        chk(bus_request, 1'b0);
    endtask : none

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        {fails, check_count} = 0;
        {reg_wr, reg_rd, reg_addr, reg_wdata, bus_grant_acknowledge} = 0;
        {core_irq_level, periodic_interrupt_timer, grant_delay} = 0;
        {hard_reset_n, wake_pin_a, wake_pin_b} = 3'h7;
        rst = 1'b1;
        r = $urandom(32'h249910d7);
        repeat (5) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        // reset values, loose bits and plain enable bits
        chk({data_bus_out, data_bus_oe, addr_bus_out, addr_bus_oe}, 8'h0a);
        chk(wake_irq_level, 3'h4);
        rd(12'h0f7, 8'h00);
        p = $urandom;
        wr(12'h0f7, p & 8'h8f);
        rd(12'h0f7, p & 8'h07);
        $display("test registers done");
        // modes 1 to 3, random park value and grant delay, each pin and timer wake source
        for (m = 1; m <= 3; m++)
        begin
            p = $urandom;
            dv = $urandom;
            grant_delay = $urandom;
            e = 8'h01 << (m - 1);
            wr(12'h0fa, {1'b0, dv, 1'b0, m[1:0]});
            chk(clock_divide_field, dv);
            wr(12'h82a, p);
            rd(12'h82a, p & 8'h07);
            wr(12'h0f7, e);
            wr(12'h0fb, 8'h27);
            cnt();
            chk(8'(n), 8'h10);
            wt(0);
            chk({6'h00, low_power_state}, 8'(m));
            chk({data_bus_oe, addr_bus_oe}, {p[0], p[0]});
            if (p[0])
                chk({data_bus_out, addr_bus_out}, {~p[1], ~p[2]});
            if (m == 1)
                wake_pin_a = 1'b0;
            else if (m == 2)
                wake_pin_b = 1'b0;
            else
                periodic_interrupt_timer = 1'b1;
            @(posedge sys_clk);
            #1;
            periodic_interrupt_timer = 1'b0;
            wt(1);
            wt(2);
            chk({clocks_stopped, low_power_state}, 8'h00);
            rd(12'h0f7, (8'h08 << m) | e);
            wr(12'h0f7, 8'h70);
            rd(12'h0f7, 8'h00);
            chk(wake_irq, 1'b0);
            {wake_pin_a, wake_pin_b} = 2'h3;
        end
        $display("test entry and wake done");
        // refusals: user state, interrupt above mask, pending event
        none(8'h07);
        core_irq_level = 3'h3;
        none(8'h22);
        core_irq_level = 3'h0;
        wr(12'h0f7, 8'h04);
        periodic_interrupt_timer = 1'b1;
        @(posedge sys_clk);
        #1;
        periodic_interrupt_timer = 1'b0;
        none(8'h27);
        wr(12'h0f7, 8'h42);
        wr(12'h0fb, 8'h27);
        repeat (5) @(posedge sys_clk);
        #1;
        wake_pin_b = 1'b0;
        cnt();
        chk(bus_request, 1'b0);
        wr(12'h0f7, 8'h70);
        wake_pin_b = 1'b1;
        $display("test refusals done");
        // acknowledge mid-count restarts the wait; hard reset wakes
        wr(12'h0fb, 8'h27);
        repeat (8) @(posedge sys_clk);
        #1;
        bus_grant_acknowledge = 1'b1;
        @(posedge sys_clk);
        #1;
        bus_grant_acknowledge = 1'b0;
        cnt();
        chk(8'(n), 8'h10);
        wt(0);
        hard_reset_n = 1'b0;
        wt(2);
        hard_reset_n = 1'b1;
        chk(clocks_stopped, 1'b0);
        rd(12'h0fb, 8'h27);
        // write protect: the setting write lands, later writes are dropped
        wr(12'h0fa, 8'h83);
        wr(12'h0fa, 8'h01);
        rd(12'h0fa, 8'h83);
        $display("test restart done");
        print_verdict();
    end
endmodule : lpw_ctrl_test
